// ### design/ldev_cfg_pkg.sv
// Package: index map, field positions, masks and reset values of the config bank
`default_nettype none
package ldev_cfg_pkg;
    // Register indices; byte address on APB is four times the index
    localparam logic [7:0] IDX_LDN       = 8'h07;
    localparam logic [7:0] IDX_TEST_ONE  = 8'h2E;
    localparam logic [7:0] IDX_TEST_TWO  = 8'h2F;
    localparam logic [7:0] IDX_ACTIVATE  = 8'h30;
    localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
    localparam logic [7:0] IDX_BASE_LOW  = 8'h61;
    localparam logic [7:0] IDX_IRQ_LEVEL = 8'h70;
    localparam logic [7:0] IDX_DMA_CHAN  = 8'h74;
    localparam logic [7:0] IDX_SPECIAL_1 = 8'hF0;
    localparam logic [7:0] IDX_SPECIAL_2 = 8'hF1;

    // Logical device numbers
    localparam logic [7:0] LDN_FLOPPY     = 8'h00;
    localparam logic [7:0] LDN_SERIAL_ONE = 8'h01;
    localparam logic [7:0] LDN_SERIAL_TWO = 8'h02;

    // Writable bit masks; every other bit is held at zero
    localparam logic [7:0] MASK_ACTIVATE  = 8'h01;
    localparam logic [7:0] MASK_BASE_HIGH = 8'h0F;
    localparam logic [7:0] MASK_BASE_LOW  = 8'hF8;
    localparam logic [7:0] MASK_IRQ_LEVEL = 8'h0F;
    localparam logic [7:0] MASK_DMA_CHAN  = 8'h07;
    localparam logic [7:0] MASK_SPECIAL   = 8'h0F;

    // Reset values
    localparam logic [7:0] RST_ZERO           = 8'h00;
    localparam logic [7:0] RST_FLOPPY_BASE_HI = 8'h03;
    localparam logic [7:0] RST_FLOPPY_BASE_LO = 8'hF0;
    localparam logic [7:0] RST_FLOPPY_IRQ     = 8'h06;
    localparam logic [7:0] RST_FLOPPY_DMA     = 8'h02;
    localparam logic [7:0] RST_SER1_BASE_HI   = 8'h03;
    localparam logic [7:0] RST_SER2_BASE_HI   = 8'h02;
    localparam logic [7:0] RST_SER_BASE_LO    = 8'hF8;
    localparam logic [7:0] RST_SER1_IRQ       = 8'h04;
    localparam logic [7:0] RST_SER2_IRQ       = 8'h03;

    // Field positions in the special configuration registers
    localparam int FLP_IRQ_SHARE_BIT  = 3;
    localparam int FLP_SWAP_BIT       = 2;
    localparam int FLP_THREE_MODE_BIT = 1;
    localparam int FLP_WR_PROTECT_BIT = 0;
    localparam int RATE_B_LSB         = 2;
    localparam int RATE_A_LSB         = 0;
    localparam int SER_MCR3_MUTE_BIT  = 3;
    localparam int SER_CLK_SRC_LSB    = 1;
    localparam int SER_IRQ_SHARE_BIT  = 0;
    localparam logic [1:0] CLK_SRC_STANDARD = 2'h0;

    // One serial port's register set
    typedef struct packed {
        logic [7:0] activate;
        logic [7:0] base_high;
        logic [7:0] base_low;
        logic [7:0] irq_level;
        logic [7:0] special_cfg;
    } serial_cfg_t;
endpackage : ldev_cfg_pkg
`default_nettype wire

// ### design/logical_device_config_bank.sv
// Configuration register bank for the floppy controller and two serial ports
`default_nettype none
module logical_device_config_bank
    import ldev_cfg_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             floppy_enable,
    output logic [15:0]      floppy_base_addr,
    output logic [3:0]       floppy_irq_level,
    output logic [2:0]       floppy_dma_channel,
    output logic             floppy_irq_share,
    output logic             floppy_drive_swap,
    output logic             floppy_three_mode,
    output logic             floppy_write_protect,
    output logic [1:0]       rate_table_select_a,
    output logic [1:0]       rate_table_select_b,
    output logic [1:0]       serial_enable,
    output logic [31:0]      serial_base_addr,
    output logic [7:0]       serial_irq_level,
    output logic [1:0]       serial_irq_share,
    output logic [3:0]       serial_clock_source,
    output logic [1:0]       serial_clock_standard,
    input  wire logic [1:0]  modem_control_reg3_fall,
    output logic [1:0]       serial_mcr3_irq
);

    // Whole state of the bank
    typedef struct packed {
        logic [7:0]       logical_device_number;
        logic [7:0]       test_one;
        logic [7:0]       test_two;
        logic [7:0]       flp_activate;
        logic [7:0]       flp_base_high;
        logic [7:0]       flp_base_low;
        logic [7:0]       flp_irq_level;
        logic [7:0]       flp_dma_channel;
        logic [7:0]       flp_special_one;
        logic [7:0]       flp_special_two;
        serial_cfg_t [1:0] serial;
        logic [31:0]      rdata;
        logic             err;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Read decode: returns {hit, data}; used for reads and to qualify writes
    function automatic logic [8:0] read_word(input logic [7:0] idx, input state_t s);
        logic [8:0]  r;
        logic        port;
        r = 9'h000;
        port = (s.logical_device_number == LDN_SERIAL_TWO);
        // Globals answer in every device number
        if (idx == IDX_LDN)
            r = {1'b1, s.logical_device_number};
        else if (idx == IDX_TEST_ONE)
            r = {1'b1, s.test_one};
        else if (idx == IDX_TEST_TWO)
            r = {1'b1, s.test_two};
        else if (s.logical_device_number == LDN_FLOPPY)
        begin
            unique case (idx)
                IDX_ACTIVATE:  r = {1'b1, s.flp_activate};
                IDX_BASE_HIGH: r = {1'b1, s.flp_base_high};
                IDX_BASE_LOW:  r = {1'b1, s.flp_base_low};
                IDX_IRQ_LEVEL: r = {1'b1, s.flp_irq_level};
                IDX_DMA_CHAN:  r = {1'b1, s.flp_dma_channel};
                IDX_SPECIAL_1: r = {1'b1, s.flp_special_one};
                IDX_SPECIAL_2: r = {1'b1, s.flp_special_two};
                default:       r = 9'h000;
            endcase
        end
        else if (s.logical_device_number == LDN_SERIAL_ONE || s.logical_device_number == LDN_SERIAL_TWO)
        begin
            unique case (idx)
                IDX_ACTIVATE:  r = {1'b1, s.serial[port].activate};
                IDX_BASE_HIGH: r = {1'b1, s.serial[port].base_high};
                IDX_BASE_LOW:  r = {1'b1, s.serial[port].base_low};
                IDX_IRQ_LEVEL: r = {1'b1, s.serial[port].irq_level};
                IDX_SPECIAL_1: r = {1'b1, s.serial[port].special_cfg};
                default:       r = 9'h000;
            endcase
        end
        return r;
    endfunction : read_word

    logic [7:0] index;
    logic       addr_ok;
    logic [8:0] lookup;
    logic       wr_fire;
    logic [7:0] wbyte;
    logic       wport;

    // Only word-aligned addresses inside the 256-word window map to an index
    assign index   = paddr[9:2];
    assign addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    assign lookup  = read_word(index, state_reg);
    assign wbyte   = pwdata[7:0];
    assign wport   = (state_reg.logical_device_number == LDN_SERIAL_TWO);
    // Write lands in the access cycle; a decode error caught in setup blocks it
    assign wr_fire = psel && penable && pwrite && pstrb[0] && !state_reg.err;

    // Next-state logic: setup cycle captures the answer, access cycle writes
    always_comb
    begin
        state_next = state_reg;
        if (psel && !penable)
        begin
            state_next.err   = !(addr_ok && lookup[8]);
            state_next.rdata = (addr_ok && !pwrite) ? {24'h000000, lookup[7:0]} : 32'h00000000;
        end
        if (wr_fire)
        begin
            // Masking on write keeps reserved bits at zero for good
            if (index == IDX_LDN)
                state_next.logical_device_number = wbyte;
            else if (index == IDX_TEST_ONE)
                state_next.test_one = wbyte;
            else if (index == IDX_TEST_TWO)
                state_next.test_two = wbyte;
            else if (state_reg.logical_device_number == LDN_FLOPPY)
            begin
                unique case (index)
                    IDX_ACTIVATE:  state_next.flp_activate = wbyte & MASK_ACTIVATE;
                    IDX_BASE_HIGH: state_next.flp_base_high = wbyte & MASK_BASE_HIGH;
                    IDX_BASE_LOW:  state_next.flp_base_low = wbyte & MASK_BASE_LOW;
                    IDX_IRQ_LEVEL: state_next.flp_irq_level = wbyte & MASK_IRQ_LEVEL;
                    IDX_DMA_CHAN:  state_next.flp_dma_channel = wbyte & MASK_DMA_CHAN;
                    IDX_SPECIAL_1: state_next.flp_special_one = wbyte & MASK_SPECIAL;
                    IDX_SPECIAL_2: state_next.flp_special_two = wbyte & MASK_SPECIAL;
                    default:       state_next.logical_device_number = state_reg.logical_device_number;
                endcase
            end
            else
            begin
                unique case (index)
                    IDX_ACTIVATE:  state_next.serial[wport].activate =
                        wbyte & MASK_ACTIVATE;
                    IDX_BASE_HIGH: state_next.serial[wport].base_high =
                        wbyte & MASK_BASE_HIGH;
                    IDX_BASE_LOW:  state_next.serial[wport].base_low =
                        wbyte & MASK_BASE_LOW;
                    IDX_IRQ_LEVEL: state_next.serial[wport].irq_level =
                        wbyte & MASK_IRQ_LEVEL;
                    IDX_SPECIAL_1: state_next.serial[wport].special_cfg =
                        wbyte & MASK_SPECIAL;
                    default:       state_next.logical_device_number = state_reg.logical_device_number;
                endcase
            end
        end
    end

    // State register with synchronous reset to the documented defaults
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_reg.logical_device_number             <= LDN_FLOPPY;
            state_reg.test_one        <= RST_ZERO;
            state_reg.test_two        <= RST_ZERO;
            state_reg.flp_activate    <= RST_ZERO;
            state_reg.flp_base_high   <= RST_FLOPPY_BASE_HI;
            state_reg.flp_base_low    <= RST_FLOPPY_BASE_LO;
            state_reg.flp_irq_level   <= RST_FLOPPY_IRQ;
            state_reg.flp_dma_channel <= RST_FLOPPY_DMA;
            state_reg.flp_special_one <= RST_ZERO;
            state_reg.flp_special_two <= RST_ZERO;
            state_reg.serial[0]       <= '{RST_ZERO, RST_SER1_BASE_HI, RST_SER_BASE_LO,
                                           RST_SER1_IRQ, RST_ZERO};
            state_reg.serial[1]       <= '{RST_ZERO, RST_SER2_BASE_HI, RST_SER_BASE_LO,
                                           RST_SER2_IRQ, RST_ZERO};
            state_reg.rdata           <= 32'h00000000;
            state_reg.err             <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Bus answers: zero wait states, data and error prepared in setup
    assign pready  = 1'b1;
    assign prdata  = state_reg.rdata;
    assign pslverr = psel && penable && state_reg.err;

    // Floppy controller configuration outputs
    assign floppy_enable        = state_reg.flp_activate[0];
    assign floppy_base_addr     = {state_reg.flp_base_high, state_reg.flp_base_low};
    assign floppy_irq_level     = state_reg.flp_irq_level[3:0];
    assign floppy_dma_channel   = state_reg.flp_dma_channel[2:0];
    assign floppy_irq_share     = state_reg.flp_special_one[FLP_IRQ_SHARE_BIT];
    assign floppy_three_mode    = state_reg.flp_special_one[FLP_THREE_MODE_BIT];
    assign floppy_drive_swap    = state_reg.flp_special_one[FLP_SWAP_BIT];
    assign floppy_write_protect = state_reg.flp_special_one[FLP_WR_PROTECT_BIT];
    assign rate_table_select_a  = state_reg.flp_special_two[RATE_A_LSB +: 2];
    assign rate_table_select_b  = state_reg.flp_special_two[RATE_B_LSB +: 2];

    // Serial port outputs; reserved clock codes are passed on but not flagged standard
    genvar p;
    generate
        for (p = 0; p < 2; p++)
        begin : g_serial
            assign serial_enable[p]           = state_reg.serial[p].activate[0];
            assign serial_base_addr[16*p +: 16] = {state_reg.serial[p].base_high,
                                                 state_reg.serial[p].base_low};
            assign serial_irq_level[4*p +: 4] = state_reg.serial[p].irq_level[3:0];
            assign serial_irq_share[p]        =
                state_reg.serial[p].special_cfg[SER_IRQ_SHARE_BIT];
            assign serial_clock_source[2*p +: 2] =
                state_reg.serial[p].special_cfg[SER_CLK_SRC_LSB +: 2];
            assign serial_clock_standard[p]   =
                (state_reg.serial[p].special_cfg[SER_CLK_SRC_LSB +: 2] == CLK_SRC_STANDARD);
            // Falling control bit 3 raises an interrupt only when not muted
            assign serial_mcr3_irq[p]         = modem_control_reg3_fall[p] &&
                !state_reg.serial[p].special_cfg[SER_MCR3_MUTE_BIT];
        end
    endgenerate

endmodule : logical_device_config_bank
`default_nettype wire

// ### testbench/logical_device_config_bank_properties.sv
// Checker: port properties of the logical device config bank
`default_nettype none
module logical_device_config_bank_properties
    import ldev_cfg_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        floppy_enable,
    input wire logic [15:0] floppy_base_addr,
    input wire logic [3:0]  floppy_irq_level,
    input wire logic [2:0]  floppy_dma_channel,
    input wire logic [31:0] serial_base_addr,
    input wire logic [3:0]  serial_clock_source,
    input wire logic [1:0]  serial_clock_standard,
    input wire logic [1:0]  modem_control_reg3_fall,
    input wire logic [1:0]  serial_mcr3_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Alignment bits are masked to zero on write and hold zero from reset
    chk_floppy_align: assert property (
        floppy_base_addr[15:12] == 4'h0 && floppy_base_addr[2:0] == 3'h0)
        else $error("floppy base alignment bits set");
    chk_serial_align: assert property (
        serial_base_addr[31:28] == 4'h0 && serial_base_addr[18:16] == 3'h0 &&
        serial_base_addr[15:12] == 4'h0 && serial_base_addr[2:0] == 3'h0)
        else $error("serial base alignment bits set");
    chk_upper_zero: assert property (prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_err_access: assert property (pslverr |-> psel && penable && prdata == 32'h0)
        else $error("error outside access or with data");
    chk_reset_levels: assert property (
        $rose(rst_n) |-> floppy_irq_level == 4'h6 && floppy_dma_channel == 3'h2)
        else $error("reset levels wrong");
    chk_enable_cause: assert property (
        $changed(floppy_enable) |-> $past(psel && penable && pwrite && paddr == 12'h0C0))
        else $error("enable changed without write");
    chk_dma_cause: assert property (
        $changed(floppy_dma_channel) |-> $past(psel && penable && pwrite && paddr == 12'h1D0))
        else $error("dma channel changed without write");
    chk_clk_flag: assert property (
        serial_clock_standard[0] == (serial_clock_source[1:0] == 2'h0))
        else $error("standard clock flag wrong");
    chk_mute_cause: assert property (serial_mcr3_irq[1] |-> modem_control_reg3_fall[1])
        else $error("interrupt without fall");
endmodule : logical_device_config_bank_properties
bind logical_device_config_bank logical_device_config_bank_properties chk_u (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .floppy_enable(floppy_enable),
    .floppy_base_addr(floppy_base_addr), .floppy_irq_level(floppy_irq_level),
    .floppy_dma_channel(floppy_dma_channel), .serial_base_addr(serial_base_addr),
    .serial_clock_source(serial_clock_source), .serial_clock_standard(serial_clock_standard),
    .modem_control_reg3_fall(modem_control_reg3_fall), .serial_mcr3_irq(serial_mcr3_irq));
`default_nettype wire

// ### testbench/logical_device_config_bank_bench.sv
// Testbench: APB register bank and output levels
`default_nettype none
module logical_device_config_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ldev_cfg_pkg::*;
    logic        core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, serial_base_addr;
    logic [15:0] floppy_base_addr, seed = 16'h3A71, fseed = 16'h3A71;
    logic [3:0]  floppy_irq_level, serial_clock_source;
    logic [2:0]  floppy_dma_channel;
    logic        floppy_enable, floppy_irq_share, floppy_drive_swap, floppy_three_mode, wp;
    logic [1:0]  rate_a, rate_b, serial_enable, serial_irq_share, clk_std, fall = 2'h0, irq;
    logic [7:0]  serial_irq_level, logical_device_number = 8'h00, idx, m [0:2][0:255];
    logic [7:0]  idxs [7] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hF0, 8'hF1};
    int          errors = 0, n_compared = 0;
    logical_device_config_bank dut_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .floppy_enable(floppy_enable),
        .floppy_base_addr(floppy_base_addr), .floppy_irq_level(floppy_irq_level),
        .floppy_dma_channel(floppy_dma_channel), .floppy_irq_share(floppy_irq_share),
        .floppy_drive_swap(floppy_drive_swap), .floppy_three_mode(floppy_three_mode),
        .floppy_write_protect(wp), .rate_table_select_a(rate_a), .rate_table_select_b(rate_b),
        .serial_enable(serial_enable), .serial_base_addr(serial_base_addr),
        .serial_irq_level(serial_irq_level), .serial_irq_share(serial_irq_share),
        .serial_clock_source(serial_clock_source), .serial_clock_standard(clk_std),
        .modem_control_reg3_fall(fall), .serial_mcr3_irq(irq));
    // Clock, 50 ns period
    always #25 core_clk = ~core_clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [7:0] rst_val(input int l, input logic [7:0] i);
        case (i)
            8'h60: return (l == 2) ? 8'h02 : 8'h03;
            8'h61: return (l == 0) ? 8'hF0 : 8'hF8;
            8'h70: return (l == 0) ? 8'h06 : ((l == 1) ? 8'h04 : 8'h03);
            8'h74: return 8'h02;
            default: return 8'h00;
        endcase
    endfunction : rst_val
    function automatic logic [7:0] wmask(input logic [7:0] i);
        case (i)
            8'h30: return 8'h01;
            8'h61: return 8'hF8;
            8'h74: return 8'h07;
            default: return 8'h0F;
        endcase
    endfunction : wmask
    // Refusal: unmapped index, device out of range, or floppy-only index on a serial port
    function automatic logic exp_err(input logic [7:0] i);
        if (i inside {8'h07, 8'h2E, 8'h2F})
            return 1'b0;
        if (!(i inside {8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hF0, 8'hF1}) || logical_device_number > 8'h02)
            return 1'b1;
        return logical_device_number != 8'h00 && i inside {8'h74, 8'hF1};
    endfunction : exp_err
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; master holds everything until pready is sampled high or 20 access cycles have passed
    task automatic acc(input logic wr, input logic [7:0] i, input logic [7:0] d);
        logic       e;
        logic [7:0] ev;
        int         n;
        e = exp_err(i);
        ev = (i == 8'h07) ? logical_device_number : ((e || i[7:4] == 4'h2) ? 8'h00 : m[logical_device_number][i]);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge core_clk); while (pready !== 1'b1 && ++n < 20);
        // A slave that never answers is a failure, not a silent pass
        if (pready !== 1'b1)
            errors++;
        chk(pslverr, e);
        if (!wr)
            chk(prdata, wr ? 8'h00 : ev);
        if (wr && !e && i == 8'h07)
            logical_device_number = d;
        else if (wr && !e)
            m[logical_device_number][i] = d & wmask(i);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : acc
    task automatic chk_ports();
        chk(floppy_enable, m[0][8'h30][0]);
        chk(floppy_base_addr, {m[0][8'h60], m[0][8'h61]});
        chk(floppy_irq_level, m[0][8'h70][3:0]);
        chk(floppy_dma_channel, m[0][8'h74][2:0]);
        chk({floppy_irq_share, floppy_drive_swap, floppy_three_mode, wp},
            m[0][8'hF0][3:0]);
        chk({rate_b, rate_a}, m[0][8'hF1][3:0]);
        chk(serial_enable, {m[2][8'h30][0], m[1][8'h30][0]});
        chk(serial_base_addr, {m[2][8'h60], m[2][8'h61], m[1][8'h60], m[1][8'h61]});
        chk(serial_irq_level, {m[2][8'h70][3:0], m[1][8'h70][3:0]});
        chk(serial_irq_share, {m[2][8'hF0][0], m[1][8'hF0][0]});
        chk(serial_clock_source, {m[2][8'hF0][2:1], m[1][8'hF0][2:1]});
        chk(clk_std, {m[2][8'hF0][2:1] == 2'h0, m[1][8'hF0][2:1] == 2'h0});
    endtask : chk_ports
    task automatic finish_test();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    // Random modem-control fall pulses; the mute bit must gate them in the same cycle
    always @(posedge core_clk)
    begin
        fseed <= lfsr(fseed);
        fall <= fseed[1:0];
    end
    always @(negedge core_clk)
        if (rst_n)
            chk(irq, fall & ~{m[2][8'hF0][3], m[1][8'hF0][3]});
    initial
    begin
        repeat (20000) @(posedge core_clk);
        errors++;
        finish_test();
    end
    initial
    begin
        for (int l = 0; l < 3; l++)
            foreach (idxs[i]) m[l][idxs[i]] = rst_val(l, idxs[i]);
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        // Reset values, then all ones written into and read back from every register of every device
        for (int l = 0; l < 3; l++)
        begin
            acc(1'b1, 8'h07, 8'(l));
            foreach (idxs[i]) acc(1'b0, idxs[i], 8'h00);
            chk_ports();
            foreach (idxs[i]) acc(1'b1, idxs[i], 8'hFF);
            foreach (idxs[i]) acc(1'b0, idxs[i], 8'h00);
            chk_ports();
        end
        acc(1'b0, 8'h2E, 8'h00);
        acc(1'b0, 8'h2F, 8'h00);
        acc(1'b1, 8'h50, 8'hFF);
        acc(1'b1, 8'h07, 8'h05);
        acc(1'b1, 8'h30, 8'h00);
        acc(1'b0, 8'h60, 8'h00);
        // Random traffic across devices and indices
        repeat (80)
        begin
            seed = lfsr(seed);
            acc(1'b1, 8'h07, 8'(seed[15:8] % 3));
            idx = idxs[seed[7:0] % 7];
            seed = lfsr(seed);
            acc(1'b1, idx, seed[7:0]);
            acc(1'b0, idx, 8'h00);
            chk_ports();
        end
        finish_test();
    end
endmodule : logical_device_config_bank_bench
`default_nettype wire
